// ---- pkg/mmc_cfg.svh ----
// memory controller constants: field positions, codes, reset values
`ifndef MMC_CFG_SVH
`define MMC_CFG_SVH
`define MMC_CFG_ENH_BIT 0
`define MMC_CFG_DRAM_BIT 1
`define MMC_CFG_MS_LSB 2
`define MMC_MS_1M_ONE 3'h1
`define MMC_MS_1M_TWO 3'h2
`define MMC_MS_2M_ONE 3'h3
`define MMC_MS_2M_TWO 3'h4
`define MMC_MS_8M_ONE 3'h5
`define MMC_MS_8M_TWO 3'h6
`define MMC_B1_512K_ONE 2'h0
`define MMC_B1_512K_TWO 2'h1
`define MMC_B1_2M_ONE 2'h2
`define MMC_B1_2M_TWO 2'h3
`define MMC_WS_FAST 2'h0
`define MMC_WS_ZERO 2'h0
`define MMC_WS_ONE 2'h1
`define MMC_WS_TWO 2'h2
`define MMC_CS_IDLE 4'hf
`define MMC_RAS_IDLE 2'h3
`define MMC_CFG_RST 12'h000
`endif

// ---- pkg/mmc_pkg.sv ----
// memory controller types: configuration, request, translation, states
package mmc_pkg;
  typedef struct packed {
    logic sram_sel;
    logic ws_ext;
    logic asym;
    logic [1:0] b1;
    logic ver_2m;
    logic [5:0] mem_cfg;
  } mmc_cfg_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [23:1] addr;
    logic [1:0] be;
  } mmc_req_t;
  typedef struct packed {
    logic [11:0] row;
    logic [11:0] col;
    logic bank;
  } mmc_xlat_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RAS = 5'h02,
    ST_CAS = 5'h04,
    ST_SRAM = 5'h08,
    ST_DONE = 5'h10
  } mmc_state_t;
endpackage

// ---- verilog/mmc_xlat.sv ----
// dram row/column address translator with registered result
`timescale 1ns/1ps
`default_nettype none
`include "mmc_cfg.svh"
module mmc_xlat
  import mmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input var mmc_cfg_t cfg,
  input wire logic [23:1] addr,
  output var mmc_xlat_t xlat_r,
  output logic forced_enh
);
  logic enh;
  // two-bank 1M x 16 has no page mode, so it always runs enhanced
  assign forced_enh = cfg.asym && cfg.b1 == `MMC_B1_2M_TWO && !cfg.mem_cfg[`MMC_CFG_ENH_BIT];
  assign enh = cfg.mem_cfg[`MMC_CFG_ENH_BIT] || forced_enh;

  function automatic mmc_xlat_t xlate(input logic e, input logic as, input logic [1:0] b1, input logic [2:0] ms,
                                      input logic [23:0] a);
    mmc_xlat_t x;
    x.row = {2'h0, a[19:10]};
    x.col = {3'h0, a[9:1]};
    x.bank = 1'b0;
    if (as)
    begin
      // asymmetric parts: row and column widths differ
      x.row = {3'h0, a[18:10]};
      if (e && b1 == `MMC_B1_512K_TWO)
      begin
        x.row = {3'h0, a[18:11], a[19]};
        x.bank = a[10];
      end
      else if (b1 == `MMC_B1_512K_TWO)
        x.bank = a[19];
      else if (b1 == `MMC_B1_2M_ONE || b1 == `MMC_B1_2M_TWO)
      begin
        x.row = {a[20], (e ? a[21] : a[9]), a[19:10]};
        x.col = {4'h0, a[8:1]};
        x.bank = e ? a[9] : 1'b0;
      end
    end
    else if (e && ms == `MMC_MS_1M_TWO)
    begin
      x.row = {2'h0, a[19:11], a[20]};
      x.bank = a[10];
    end
    else if (e && ms == `MMC_MS_2M_TWO)
    begin
      x.row = {2'h0, a[19:12], a[21], a[20]};
      x.col = {2'h0, a[10:1]};
      x.bank = a[11];
    end
    else if (e && ms == `MMC_MS_8M_TWO)
    begin
      x.row = {1'b0, a[22], a[19:13], a[23], a[21], a[20]};
      x.col = {1'b0, a[11:1]};
      x.bank = a[12];
    end
    else
    begin
      case (ms)
        `MMC_MS_1M_TWO: x.bank = a[20];
        `MMC_MS_2M_ONE, `MMC_MS_2M_TWO:
        begin
          x.row = {2'h0, a[19:11], a[20]};
          x.col = {2'h0, a[10:1]};
          x.bank = (ms == `MMC_MS_2M_TWO) ? a[21] : 1'b0;
        end
        `MMC_MS_8M_ONE, `MMC_MS_8M_TWO:
        begin
          x.row = {1'b0, a[22], a[19:12], a[21], a[20]};
          x.col = {1'b0, a[11:1]};
          x.bank = (ms == `MMC_MS_8M_TWO) ? a[23] : 1'b0;
        end
        default: x.bank = 1'b0;
      endcase
    end
    return x;
  endfunction

  // per-configuration mux of row and column bits
  always_ff @(posedge clk)
  begin
    if (rst)
      xlat_r <= '0;
    else if (load)
      xlat_r <= xlate(enh, cfg.asym, cfg.b1, cfg.mem_cfg[`MMC_CFG_MS_LSB +: 3], {addr, 1'b0});
  end

  AST_ENH_TWO_BANK_ASYM: assert property (@(posedge clk) disable iff (rst)
    (load && cfg.asym && cfg.b1 == `MMC_B1_2M_TWO) |=> (xlat_r.row[10] == $past(addr[21]) && xlat_r.bank == $past(addr[9])))
    else $error("two-bank 1M x 16 not translated in enhanced page mode");
  AST_ENH_ROW_LSB: assert property (@(posedge clk) disable iff (rst)
    (load && !cfg.asym && cfg.mem_cfg[`MMC_CFG_ENH_BIT] && cfg.mem_cfg[4:2] == `MMC_MS_8M_TWO)
    |=> (xlat_r.row[2] == $past(addr[23]) && xlat_r.bank == $past(addr[12])))
    else $error("enhanced 16M row mux wrong");
endmodule
`default_nettype wire

// ---- verilog/mmc_ctrl.sv ----
// main memory controller: dram row/column cycles and sram selects
// Operation
// - no page mode for two-bank 1Mx16
// - enable bit set selects enhanced address mux
// - dram bit required; sram reuses bits as waits
// - asymmetric row/column widths for 512Kx8, 1Mx16
// - sram up to 16M, two 16-bit banks
// - sram select reuses column strobes as selects
// - selects map bank0 low/high, bank1 low/high
// - sram drives word address and write strobe
// - size bits set sram size and split
// - sram wait states follow two config bits
// - reset defaults to dram interface
// - muxed dram address shares upper address pins
`timescale 1ns/1ps
`default_nettype none
`include "mmc_cfg.svh"
module mmc_ctrl
  import mmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input var mmc_cfg_t cfg_in,
  input var mmc_req_t req,
  output logic req_ready,
  output logic req_done,
  output logic [23:1] system_word_address,
  output logic [11:0] muxed_dram_address,
  output logic [3:0] col_strobe_n,
  output logic [1:0] row_strobe_n,
  output logic memory_write_strobe_n,
  output logic sram_mode,
  output logic dram_cfg_bad,
  output logic page_mode_forced
);
  mmc_state_t st_r, st_nxt;
  mmc_cfg_t cfg_r;
  mmc_req_t req_r;
  mmc_xlat_t xl;
  logic [1:0] cnt_r;
  logic [1:0] ws_rd, ws_wr;
  logic accept;
  logic sram_bank;
  logic sram_in_range;
  logic [23:1] sa_r, sa_nxt;
  logic [11:0] ma_r, ma_nxt;
  logic [3:0] cs_r, cs_nxt;
  logic [1:0] ras_r, ras_nxt;
  logic we_r, we_nxt;

  // wait states from config bits 1:0, the extended-wait bit and the access direction
  function automatic logic [1:0] sram_waits(input logic [1:0] sel, input logic ext, input logic wr);
    logic [1:0] w;
    w = ext ? `MMC_WS_TWO : `MMC_WS_ONE;
    if (sel == `MMC_WS_FAST)
      w = wr ? `MMC_WS_ONE : `MMC_WS_ZERO;
    return w;
  endfunction

  // ma bit i lands on sa(23-i) for i<10, ma10 on sa13, ma11 on sa12
  function automatic logic [23:12] pin_share(input logic [11:0] ma);
    logic [23:12] s;
    for (int i = 0; i < 10; i++)
      s[23 - i] = ma[i];
    s[13] = ma[10];
    s[12] = ma[11];
    return s;
  endfunction

  assign ws_rd = sram_waits(cfg_r.mem_cfg[1:0], cfg_r.ws_ext, 1'b0);
  assign ws_wr = sram_waits(cfg_r.mem_cfg[1:0], cfg_r.ws_ext, 1'b1);
  assign req_ready = (st_r == ST_IDLE);
  assign accept = req_ready && req.valid;
  assign req_done = (st_r == ST_DONE);
  assign sram_mode = cfg_r.sram_sel;
  // bit 1 clear outside sram means dram cannot run
  assign dram_cfg_bad = !cfg_r.sram_sel && !cfg_r.mem_cfg[`MMC_CFG_DRAM_BIT];

  mmc_xlat u_xlat (
    .clk(clk),
    .rst(rst),
    .load(accept),
    .cfg(cfg_r),
    .addr(req.addr),
    .xlat_r(xl),
    .forced_enh(page_mode_forced)
  );

  // config is only taken between accesses so a cycle never changes mode midway
  always_ff @(posedge clk)
  begin
    if (rst)
      cfg_r <= `MMC_CFG_RST;
    else if (st_r == ST_IDLE && !req.valid)
      cfg_r <= cfg_in;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      req_r <= '0;
    else if (accept)
      req_r <= req;
  end

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE:
        if (accept)
          st_nxt = cfg_r.sram_sel ? ST_SRAM : ST_RAS;
      ST_RAS: st_nxt = ST_CAS;
      ST_CAS: st_nxt = ST_DONE;
      ST_SRAM:
        if (cnt_r == 2'h0)
          st_nxt = ST_DONE;
      ST_DONE: st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st_r <= ST_IDLE;
    else
      st_r <= st_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_r <= 2'h0;
    else if (accept)
      cnt_r <= req.write ? ws_wr : ws_rd;
    else if (st_r == ST_SRAM && cnt_r != 2'h0)
      cnt_r <= cnt_r - 2'h1;
  end

  // sram bank split follows the size bits; two-bank codes pick bank 1 high up
  always_comb
  begin
    sram_bank = 1'b0;
    sram_in_range = 1'b1;
    case (cfg_r.mem_cfg[`MMC_CFG_MS_LSB +: 3])
      `MMC_MS_1M_ONE: sram_in_range = (req_r.addr[23:20] == 4'h0);
      `MMC_MS_1M_TWO:
      begin
        sram_bank = req_r.addr[20];
        sram_in_range = (req_r.addr[23:21] == 3'h0);
      end
      `MMC_MS_2M_ONE: sram_in_range = (req_r.addr[23:21] == 3'h0);
      `MMC_MS_2M_TWO:
      begin
        sram_bank = req_r.addr[21];
        sram_in_range = (req_r.addr[23:22] == 2'h0);
      end
      `MMC_MS_8M_ONE: sram_in_range = !req_r.addr[23];
      `MMC_MS_8M_TWO: sram_bank = req_r.addr[23];
      default: sram_in_range = 1'b0;
    endcase
  end

  // pin values for the next cycle; pins lag the state by one clock
  always_comb
  begin
    sa_nxt = sa_r;
    ma_nxt = ma_r;
    cs_nxt = `MMC_CS_IDLE;
    ras_nxt = `MMC_RAS_IDLE;
    we_nxt = 1'b1;
    case (st_r)
      ST_RAS:
      begin
        ma_nxt = xl.row;
        ras_nxt[xl.bank] = 1'b0;
      end
      ST_CAS:
      begin
        ma_nxt = xl.col;
        ras_nxt[xl.bank] = 1'b0;
        cs_nxt = xl.bank ? {~req_r.be, 2'h3} : {2'h3, ~req_r.be};
        we_nxt = !req_r.write;
      end
      ST_SRAM:
      begin
        sa_nxt = req_r.addr;
        if (sram_in_range)
          cs_nxt = sram_bank ? {~req_r.be, 2'h3} : {2'h3, ~req_r.be};
        we_nxt = !req_r.write;
      end
      ST_IDLE, ST_DONE: we_nxt = 1'b1;
      default: we_nxt = 1'b1;
    endcase
    if (st_r == ST_RAS || st_r == ST_CAS)
      sa_nxt = {pin_share(ma_nxt), sa_r[11:1]};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sa_r <= '0;
      ma_r <= '0;
      cs_r <= `MMC_CS_IDLE;
      ras_r <= `MMC_RAS_IDLE;
      we_r <= 1'b1;
    end
    else
    begin
      sa_r <= sa_nxt;
      ma_r <= ma_nxt;
      cs_r <= cs_nxt;
      ras_r <= ras_nxt;
      we_r <= we_nxt;
    end
  end

  assign system_word_address = sa_r;
  assign muxed_dram_address = ma_r;
  // same four pins: column strobes in dram mode, byte selects in sram mode
  assign col_strobe_n = cs_r;
  assign row_strobe_n = ras_r;
  assign memory_write_strobe_n = we_r;

  AST_RESET_DRAM: assert property (@(posedge clk) $past(rst) |-> !sram_mode)
    else $error("sram mode active right after reset");
  AST_SRAM_NO_RAS: assert property (@(posedge clk) disable iff (rst)
    (st_r == ST_SRAM) |=> (row_strobe_n == `MMC_RAS_IDLE))
    else $error("row strobe during sram access");
  AST_CS_MAP: assert property (@(posedge clk) disable iff (rst)
    (st_r == ST_SRAM && sram_in_range && sram_bank && req_r.be == 2'h2)
    |=> (col_strobe_n == 4'h7))
    else $error("sram select mapping wrong");
  AST_WS_READ_ZERO: assert property (@(posedge clk) disable iff (rst)
    (accept && cfg_r.sram_sel && !req.write && cfg_r.mem_cfg[1:0] == 2'h0)
    |=> !req_done ##1 req_done)
    else $error("zero-wait sram read timing wrong");
  AST_WS_WRITE_ONE: assert property (@(posedge clk) disable iff (rst)
    (accept && cfg_r.sram_sel && req.write && cfg_r.mem_cfg[1:0] == 2'h0)
    |=> !req_done [*2] ##1 req_done)
    else $error("one-wait sram write timing wrong");
  AST_WS_TWO: assert property (@(posedge clk) disable iff (rst)
    (accept && cfg_r.sram_sel && cfg_r.ws_ext && cfg_r.mem_cfg[1:0] == 2'h1)
    |=> !req_done [*3] ##1 req_done)
    else $error("two-wait sram timing wrong");
  AST_WE_WRITE_ONLY: assert property (@(posedge clk) disable iff (rst)
    !memory_write_strobe_n |-> $past(req_r.write) && $past(st_r == ST_SRAM || st_r == ST_CAS))
    else $error("write strobe outside a write cycle");
  AST_PIN_SHARE: assert property (@(posedge clk) disable iff (rst)
    (st_r == ST_CAS) |-> (system_word_address[12] == muxed_dram_address[11]
    && system_word_address[23] == muxed_dram_address[0]))
    else $error("dram address not on shared pins");
endmodule
`default_nettype wire

// ---- tb/mmc_mem_model.sv ----
// memory bank model: watches sram selects and counts accesses
`timescale 1ns/1ps
`default_nettype none
module mmc_mem_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sram_mode,
  input wire logic [3:0] sel_n,
  input wire logic we_n,
  output logic [7:0] access_count,
  output logic bank1_hit,
  output logic last_write
);
  logic [3:0] prev_sel_n_r;
  // bank 1 owns the two upper selects, bank 0 the lower two
  assign bank1_hit = ~&sel_n[3:2];
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prev_sel_n_r <= 4'hf;
      access_count <= 8'h00;
      last_write <= 1'b0;
    end
    else
    begin
      prev_sel_n_r <= sel_n;
      // one access per falling select edge; no data bus to answer
      if (sram_mode && sel_n != 4'hf && prev_sel_n_r == 4'hf)
      begin
        access_count <= access_count + 8'h01;
        last_write <= ~we_n;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/test_mmc_ctrl.sv ----
// self-checking testbench for the main memory controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("[ERR] %s exp=%h got=%h", nm, e, g); end end
module test_mmc_ctrl
  import mmc_pkg::*;
;
  logic clk, rst, rdy, done, smode, bad, forced, we_n, bank1, lastw;
  mmc_cfg_t cfg;
  mmc_req_t req;
  logic [23:1] sa, sa_c, ad;
  logic [11:0] ma, row_c, col_c;
  logic [3:0] cs_n, cs_c;
  logic [1:0] ras_n, ras_c;
  logic [7:0] acc;
  logic we_c;
  int errors, checked, lat;
  mmc_ctrl mmc_ctrl_inst (.clk(clk), .rst(rst), .cfg_in(cfg), .req(req), .req_ready(rdy), .req_done(done),
    .system_word_address(sa), .muxed_dram_address(ma), .col_strobe_n(cs_n), .row_strobe_n(ras_n),
    .memory_write_strobe_n(we_n), .sram_mode(smode), .dram_cfg_bad(bad), .page_mode_forced(forced));
  mmc_mem_model mmc_mem_model_inst (.clk(clk), .rst(rst), .sram_mode(smode), .sel_n(cs_n), .we_n(we_n),
    .access_count(acc), .bank1_hit(bank1), .last_write(lastw));
  function automatic logic [3:0] sel(input logic b, input logic [1:0] be);
    return ~{b & be[1], b & be[0], ~b & be[1], ~b & be[0]};
  endfunction
  function automatic logic [23:12] sa_of(input logic [11:0] m);
    logic [23:12] r;
    for (int i = 0; i < 10; i++)
      r[23 - i] = m[i];
    r[13] = m[10];
    r[12] = m[11];
    return r;
  endfunction
  task automatic set_cfg(input logic s, w, a, input logic [1:0] b, input logic [5:0] m);
    @(posedge clk);
    // only the 2M-per-pair enhanced code wants the version bit
    cfg <= '{sram_sel: s, ws_ext: w, asym: a, b1: b, ver_2m: (m[4:2] == 3'h2) && m[0], mem_cfg: m};
    req.valid <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic do_req(input logic wr, input logic [1:0] be);
    @(posedge clk);
    req <= '{valid: 1'b1, write: wr, addr: ad, be: be};
    @(posedge clk);
    req.valid <= 1'b0;
    lat = 0;
    for (int k = 0; k < 10; k++)
    begin
      @(posedge clk);
      #1;
      lat++;
      if (ras_n !== 2'b11 && cs_n === 4'hf)
        row_c = ma;
      if (done === 1'b1)
      begin
        col_c = ma;
        cs_c = cs_n;
        ras_c = ras_n;
        we_c = we_n;
        sa_c = sa;
        break;
      end
    end
  endtask
  task automatic t_reset;
    `CHK("sram_mode", 1'b0, smode)
    `CHK("strobes", 4'hf, cs_n)
    `CHK("ready", 1'b1, rdy)
  endtask
  task automatic t_page;
    set_cfg(1'b0, 1'b0, 1'b0, 2'h0, 6'h05);
    `CHK("cfg_bad", 1'b1, bad)
    set_cfg(1'b0, 1'b0, 1'b0, 2'h0, 6'h06);
    `CHK("cfg_ok", 1'b0, bad)
    ad = 23'h05a5a5;
    do_req(1'b1, 2'b11);
    // done shows two edges after the accepting edge
    `CHK("lat", 2, lat)
    `CHK("row", ad[19:10], row_c[9:0])
    `CHK("col", ad[9:1], col_c[8:0])
    `CHK("cas", 4'b1100, cs_c)
    `CHK("ras", 2'b10, ras_c)
    `CHK("we", 1'b0, we_c)
    `CHK("sa", sa_of(col_c), sa_c[23:12])
  endtask
  task automatic t_enh16;
    set_cfg(1'b0, 1'b0, 1'b0, 2'h0, 6'h1b);
    ad = 23'h7abcde;
    do_req(1'b0, 2'b01);
    `CHK("row", {ad[22], ad[19:13], ad[23], ad[21], ad[20]}, row_c[10:0])
    `CHK("col", ad[11:1], col_c[10:0])
    `CHK("cas", sel(1'b1, 2'b01), cs_c)
    `CHK("ras", 2'b01, ras_c)
    `CHK("we", 1'b1, we_c)
  endtask
  task automatic t_enh2;
    // enhanced two-bank codes: 1M per bank, then 2M per bank
    set_cfg(1'b0, 1'b0, 1'b0, 2'h0, 6'h0b);
    ad = 23'h1c3a5b;
    do_req(1'b1, 2'b10);
    `CHK("lat", 2, lat)
    `CHK("row", {ad[19:11], ad[20]}, row_c[9:0])
    `CHK("col", ad[9:1], col_c[8:0])
    `CHK("cas", sel(ad[10], 2'b10), cs_c)
    `CHK("ras", {~ad[10], ad[10]}, ras_c)
    `CHK("we", 1'b0, we_c)
    set_cfg(1'b0, 1'b0, 1'b0, 2'h0, 6'h13);
    ad = 23'h2d4b96;
    do_req(1'b0, 2'b11);
    `CHK("row", {ad[19:12], ad[21], ad[20]}, row_c[9:0])
    `CHK("col", ad[10:1], col_c[9:0])
    `CHK("cas", sel(ad[11], 2'b11), cs_c)
    `CHK("ras", {~ad[11], ad[11]}, ras_c)
  endtask
  task automatic t_asym;
    for (int e = 1; e >= 0; e--)
    begin
      // enhanced bit set first as software must, then left clear
      set_cfg(1'b0, 1'b0, 1'b1, 2'b11, {5'b00001, e[0]});
      `CHK("forced", ~e[0], forced)
      ad = 23'h3655aa;
      do_req(1'b0, 2'b11);
      `CHK("row", {ad[20], ad[21], ad[19:10]}, row_c)
      `CHK("col", ad[8:1], col_c[7:0])
      `CHK("cas", 4'b0011, cs_c)
      `CHK("ras", 2'b01, ras_c)
    end
  endtask
  task automatic t_sram;
    logic [1:0] be;
    int ws;
    for (int i = 0; i < 6; i++)
    begin
      be = (i >= 4) ? 2'b11 : ((i == 0 || i == 3) ? 2'b01 : 2'b10);
      ws = (i < 2) ? 0 : ((i >= 4) ? 2 : 1);
      // size code 110: two 8M banks, bank picked by the top address bit
      set_cfg(1'b1, i >= 4, 1'b0, 2'h0, {5'b01100, i >= 2});
      `CHK("sram_mode", 1'b1, smode)
      ad = {i[0], 22'h2b3c4d};
      do_req(i[0], be);
      `CHK("lat", 1 + ((ws == 0) ? i[0] : ws), lat)
      `CHK("sel", sel(i[0], be), cs_c)
      `CHK("sa", ad, sa_c)
      `CHK("we", ~i[0], we_c)
      `CHK("bank", i[0], bank1)
    end
    `CHK("accesses", 8'h06, acc)
    `CHK("last_write", 1'b1, lastw)
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    // about 100 cycles expected; generous margin
    repeat (5000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  initial
  begin
    rst = 1'b1;
    cfg = '0;
    req = '0;
    errors = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_page();
    t_enh16();
    t_enh2();
    t_asym();
    t_sram();
    tally_and_finish();
  end
endmodule
`default_nettype wire
